// ---- pkg/acx_defs.vh ----
// register map, field positions, reset values and codes of the audio crossover
`ifndef ACX_DEFS_VH
`define ACX_DEFS_VH

// register byte offsets
`define ACX_REG_CTRL 8'h00
`define ACX_REG_BAND 8'h04
`define ACX_REG_STAT 8'h08
`define ACX_REG_FILT0 8'h10
`define ACX_REG_FILT5 8'h24

// field positions
`define ACX_CTRL_WAYS_LSB 0
`define ACX_CTRL_LINK_LSB 4
`define ACX_BAND_POL_LSB 0
`define ACX_BAND_MUTE_LSB 8
`define ACX_STAT_BUSY_BIT 0
`define ACX_STAT_REJ_BIT 1
`define ACX_FILT_FREQ_LSB 0
`define ACX_FILT_FAM_LSB 16
`define ACX_FILT_SLOPE_LSB 18

// reset values
`define ACX_WAYS_RST 2'h1
`define ACX_FREQ_RST 16'h03e8
`define ACX_FAM_RST 2'h0
`define ACX_SLOPE_RST 3'h3

// filter family codes
`define ACX_FAM_BW 2'h0
`define ACX_FAM_BES 2'h1
`define ACX_FAM_LR 2'h2

// slope codes: 6, 12, 18, 24, 36, 48 dB per octave
`define ACX_SLOPE_6 3'h0
`define ACX_SLOPE_12 3'h1
`define ACX_SLOPE_18 3'h2
`define ACX_SLOPE_24 3'h3
`define ACX_SLOPE_36 3'h4
`define ACX_SLOPE_48 3'h5

// one-pole coefficient per hertz, Q8 of 2*pi*65536/48000
`define ACX_ALPHA_K 12'h894
`define ACX_ALPHA_ONE 17'h10000

`endif

// ---- logic/acx_pole_stage.v ----
// one first-order section: low-pass state update, high-pass or low-pass output
`timescale 1ns/1ps
`default_nettype none

module acx_pole_stage #(
    parameter IW = 28
) (
    input wire signed [IW-1:0] x,
    input wire signed [IW-1:0] y,
    input wire [16:0] alpha,
    input wire highPass,
    output wire signed [IW-1:0] yNew,
    output wire signed [IW-1:0] out
);

    wire signed [IW:0] diff;
    wire signed [IW+18:0] prod;
    wire signed [IW+2:0] step;

    // y += alpha * (x - y), alpha in Q16
    assign diff = x - y;
    assign prod = diff * $signed({1'b0, alpha});
    assign step = prod[IW+18:16];
    assign yNew = y + $signed(step[IW-1:0]);
    // high-pass is the residue of the low-pass
    assign out = highPass ? x - yNew : yNew;

endmodule // acx_pole_stage

`default_nettype wire

// ---- logic/acx_crossover.v ----
// multi-way audio crossover with apb control and per-band filter chains
//
// Notes on behaviour
// - two-way setting splits input into low and high outputs
// - three-way setting gives low, mid and high outputs
// - four-way setting gives low, lower-mid, upper-mid and high outputs
// - every filter holds its own family and slope
// - butterworth 6 to 48, bessel 12 to 48 dB per octave
// - linkwitz-riley 12, 24, 36, 48; no 18 dB per octave
// - corner frequency set in one hertz steps
// - with link on, a frequency write also sets the adjacent filter
// - link only when both filters butterworth or both linkwitz-riley
// - with link off, adjacent frequencies stay independent
// - reversed polarity inverts the band's sign
// - each band has its own mute that silences it
// - each mid band has separate upper and lower edge filters
`timescale 1ns/1ps
`default_nettype none
`include "acx_defs.vh"

module acx_crossover #(
    parameter DW = 24,
    parameter IW = 28
) (
    input wire clk_sys,
    input wire arst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire sampleValid,
    input wire signed [DW-1:0] sampleIn,
    output reg sampleReady,
    output reg outValid,
    output reg signed [DW-1:0] lowBandOutput,
    output reg signed [DW-1:0] lowerMiddleBandOutput,
    output reg signed [DW-1:0] upperMiddleBandOutput,
    output reg signed [DW-1:0] highBandOutput
);

    localparam ST_INIT = 2'b00;
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN = 2'b10;
    localparam ST_DONE = 2'b11;
    localparam [5:0] MEM_LAST = 6'h2f;

    // legal family and slope pairs
    function typeOk;
        input [1:0] fam;
        input [2:0] slope;
        begin
            case (fam)
                `ACX_FAM_BW: typeOk = (slope <= `ACX_SLOPE_48);
                `ACX_FAM_BES: typeOk = (slope >= `ACX_SLOPE_12)
                    && (slope <= `ACX_SLOPE_48);
                `ACX_FAM_LR: typeOk = (slope == `ACX_SLOPE_12) || (slope >= `ACX_SLOPE_24)
                    && (slope <= `ACX_SLOPE_48);
                default: typeOk = 1'b0;
            endcase
        end
    endfunction

    // families that may be linked
    function compat;
        input [1:0] fa;
        input [1:0] fb;
        begin
            compat = (fa == fb) && ((fa == `ACX_FAM_BW) || (fa == `ACX_FAM_LR));
        end
    endfunction

    // first-order sections per slope
    function [3:0] stageCount;
        input [2:0] slope;
        begin
            case (slope)
                `ACX_SLOPE_6: stageCount = 4'h1;
                `ACX_SLOPE_12: stageCount = 4'h2;
                `ACX_SLOPE_18: stageCount = 4'h3;
                `ACX_SLOPE_24: stageCount = 4'h4;
                `ACX_SLOPE_36: stageCount = 4'h6;
                `ACX_SLOPE_48: stageCount = 4'h8;
                default: stageCount = 4'h1;
            endcase
        end
    endfunction

    // corner frequency in hertz to Q16 coefficient, clamped at one
    function [16:0] alphaOf;
        input [15:0] f;
        reg [27:0] p;
        begin
            p = f * `ACX_ALPHA_K;
            alphaOf = (p[27:8] > {3'h0, `ACX_ALPHA_ONE}) ? `ACX_ALPHA_ONE : p[24:8];
        end
    endfunction

    // saturate internal width to sample width
    function signed [DW-1:0] sat;
        input signed [IW-1:0] v;
        reg signed [IW-1:0] hi;
        reg signed [IW-1:0] lo;
        begin
            hi = {{(IW-DW+1){1'b0}}, {(DW-1){1'b1}}};
            lo = {{(IW-DW+1){1'b1}}, {(DW-1){1'b0}}};
            sat = (v > hi) ? hi[DW-1:0] : (v < lo) ? lo[DW-1:0] : v[DW-1:0];
        end
    endfunction

    // control registers
    reg [1:0] ways_r;
    reg [2:0] link_r;
    reg [3:0] pol_r;
    reg [3:0] mute_r;
    reg rej_r;
    reg [15:0] freq_r [0:5];
    reg [1:0] fam_r [0:5];
    reg [2:0] slope_r [0:5];

    // sequencer state
    reg [1:0] st_r;
    reg [5:0] initCnt_r;
    reg [1:0] band_r;
    reg ph_r;
    reg [3:0] stg_r;
    reg signed [IW-1:0] x_r;
    reg signed [IW-1:0] acc_r;
    reg [3:0] polSnap_r;
    reg [3:0] muteSnap_r;
    reg signed [DW-1:0] res_r [0:3];
    reg signed [IW-1:0] stateMem [0:47];

    // apb decode
    wire acc = psel & penable & pready;
    wire wr = acc & pwrite;
    wire isCtrl = (paddr == `ACX_REG_CTRL);
    wire isBand = (paddr == `ACX_REG_BAND);
    wire isStat = (paddr == `ACX_REG_STAT);
    wire filtHit = (paddr >= `ACX_REG_FILT0) && (paddr <= `ACX_REG_FILT5) && (paddr[1:0] == 2'h0);
    wire [7:0] fOff = paddr - `ACX_REG_FILT0;
    wire [2:0] fIdx = fOff[4:2];
    wire [2:0] pIdx = fIdx ^ 3'h1;
    wire mapped = isCtrl | isBand | isStat | filtHit;

    // write checks
    wire [15:0] wFreq = pwdata[`ACX_FILT_FREQ_LSB+15:`ACX_FILT_FREQ_LSB];
    wire [1:0] wFam = pwdata[`ACX_FILT_FAM_LSB+1:`ACX_FILT_FAM_LSB];
    wire [2:0] wSlope = pwdata[`ACX_FILT_SLOPE_LSB+2:`ACX_FILT_SLOPE_LSB];
    wire filtOk = typeOk(wFam, wSlope) && (wFreq != 16'h0000);
    wire pairOk = compat(wFam, fam_r[pIdx]);
    wire [1:0] wWays = pwdata[`ACX_CTRL_WAYS_LSB+1:`ACX_CTRL_WAYS_LSB];
    wire [2:0] linkReq = pwdata[`ACX_CTRL_LINK_LSB+2:`ACX_CTRL_LINK_LSB];
    wire [2:0] linkOkMask = {compat(fam_r[4], fam_r[5]), compat(fam_r[2], fam_r[3]),
        compat(fam_r[0], fam_r[1])};
    wire ctrlBad = (wWays == 2'h0) || (|(linkReq & ~linkOkMask));
    wire rejSet = wr & ((isCtrl & ctrlBad) | (filtHit & ~filtOk));
    wire rejClr = wr & isStat & pwdata[`ACX_STAT_REJ_BIT];

    // read mux
    reg [31:0] rdata;
    always @* begin
        rdata = 32'h0;
        if (isCtrl) begin
            rdata = {25'h0, link_r, 2'h0, ways_r};
        end else if (isBand) begin
            rdata = {20'h0, mute_r, 4'h0, pol_r};
        end else if (isStat) begin
            rdata = {30'h0, rej_r, st_r != ST_IDLE};
        end else if (filtHit) begin
            rdata = {11'h0, slope_r[fIdx], fam_r[fIdx], freq_r[fIdx]};
        end
    end

    // apb answer: pready one cycle into the access phase
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            if (psel & penable & ~pready) begin
                prdata <= pwrite ? 32'h0 : rdata;
                pslverr <= ~mapped;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // register writes
    integer i, j;
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ways_r <= `ACX_WAYS_RST;
            link_r <= 3'h0;
            pol_r <= 4'h0;
            mute_r <= 4'h0;
            rej_r <= 1'b0;
            for (i = 0; i < 6; i = i + 1) begin
                freq_r[i] <= `ACX_FREQ_RST;
                fam_r[i] <= `ACX_FAM_RST;
                slope_r[i] <= `ACX_SLOPE_RST;
            end
        end else begin
            rej_r <= rejSet | (rej_r & ~rejClr); // set wins over clear
            if (wr & isCtrl & ~ctrlBad) begin
                ways_r <= wWays;
                link_r <= linkReq & linkOkMask;
            end
            if (wr & isBand) begin
                pol_r <= pwdata[`ACX_BAND_POL_LSB+3:`ACX_BAND_POL_LSB];
                mute_r <= pwdata[`ACX_BAND_MUTE_LSB+3:`ACX_BAND_MUTE_LSB];
            end
            if (wr & filtHit & filtOk) begin
                freq_r[fIdx] <= wFreq;
                fam_r[fIdx] <= wFam;
                slope_r[fIdx] <= wSlope;
                if (link_r[fIdx[2:1]] & pairOk) begin
                    freq_r[pIdx] <= wFreq;
                end else begin
                    link_r[fIdx[2:1]] <= 1'b0;
                end
            end
        end
    end

    // current filter: high-pass lower edge, then low-pass upper edge
    wire [1:0] bandDn = band_r - 2'h1;
    wire [2:0] fid = ph_r ? {band_r, 1'b0} : {bandDn, 1'b1};
    wire fExists = ph_r ? (band_r < ways_r) : (band_r != 2'h0);
    wire [3:0] nst = stageCount(slope_r[fid]);
    wire doStage = (st_r == ST_RUN) && fExists && (stg_r < nst);
    wire [5:0] memAddr = {fid, stg_r[2:0]};
    wire signed [IW-1:0] yNew;
    wire signed [IW-1:0] yOut;
    wire signed [IW-1:0] accNeg = -acc_r;

    acx_pole_stage #(
        .IW(IW)
    ) u_stage (
        .x(acc_r),
        .y(stateMem[memAddr]),
        .alpha(alphaOf(freq_r[fid])),
        .highPass(~ph_r),
        .yNew(yNew),
        .out(yOut)
    );

    // filter state memory, cleared after reset
    always @(posedge clk_sys) begin
        if (st_r == ST_INIT) begin
            stateMem[initCnt_r] <= {IW{1'b0}};
        end else if (doStage) begin
            stateMem[memAddr] <= yNew;
        end
    end

    // sample sequencer
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= ST_INIT;
            initCnt_r <= 6'h0;
            band_r <= 2'h0;
            ph_r <= 1'b0;
            stg_r <= 4'h0;
            x_r <= {IW{1'b0}};
            acc_r <= {IW{1'b0}};
            polSnap_r <= 4'h0;
            muteSnap_r <= 4'h0;
            for (j = 0; j < 4; j = j + 1) begin
                res_r[j] <= {DW{1'b0}};
            end
            sampleReady <= 1'b0;
            outValid <= 1'b0;
            lowBandOutput <= {DW{1'b0}};
            lowerMiddleBandOutput <= {DW{1'b0}};
            upperMiddleBandOutput <= {DW{1'b0}};
            highBandOutput <= {DW{1'b0}};
        end else begin
            outValid <= 1'b0;
            case (st_r)
                ST_INIT: begin
                    initCnt_r <= initCnt_r + 6'h1;
                    if (initCnt_r == MEM_LAST) begin
                        st_r <= ST_IDLE;
                        sampleReady <= 1'b1;
                    end
                end
                ST_IDLE: begin
                    if (sampleValid) begin
                        x_r <= {{(IW-DW){sampleIn[DW-1]}}, sampleIn};
                        acc_r <= {{(IW-DW){sampleIn[DW-1]}}, sampleIn};
                        band_r <= 2'h0;
                        ph_r <= 1'b0;
                        stg_r <= 4'h0;
                        polSnap_r <= pol_r;
                        muteSnap_r <= mute_r;
                        sampleReady <= 1'b0;
                        st_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (doStage) begin
                        acc_r <= yOut;
                        stg_r <= stg_r + 4'h1;
                    end else begin
                        stg_r <= 4'h0;
                        if (!ph_r) begin
                            ph_r <= 1'b1;
                        end else begin
                            if (muteSnap_r[band_r]) begin
                                res_r[band_r] <= {DW{1'b0}};
                            end else begin
                                res_r[band_r] <= sat(polSnap_r[band_r] ? accNeg : acc_r);
                            end
                            ph_r <= 1'b0;
                            acc_r <= x_r;
                            if (band_r == ways_r) begin
                                st_r <= ST_DONE;
                            end else begin
                                band_r <= band_r + 2'h1;
                            end
                        end
                    end
                end
                ST_DONE: begin
                    // all bands update together
                    outValid <= 1'b1;
                    lowBandOutput <= res_r[0];
                    highBandOutput <= res_r[ways_r];
                    lowerMiddleBandOutput <= (ways_r >= 2'h2) ? res_r[1] : {DW{1'b0}};
                    upperMiddleBandOutput <= (ways_r == 2'h3) ? res_r[2] : {DW{1'b0}};
                    sampleReady <= 1'b1;
                    st_r <= ST_IDLE;
                end
                default: begin
                    st_r <= ST_IDLE;
                    sampleReady <= 1'b1;
                end
            endcase
        end
    end

endmodule // acx_crossover

`default_nettype wire

// ---- tb/acx_crossover_assertions.sv ----
// bus and stream timing checks of the audio crossover
`timescale 1ns/1ps
`default_nettype none
module acx_crossover_chk #(parameter DW = 24) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sampleValid,
    input wire logic sampleReady,
    input wire logic outValid,
    input wire logic signed [DW-1:0] lowBandOutput,
    input wire logic signed [DW-1:0] highBandOutput
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // first access cycle, then answer after exactly one wait state
    sequence accessStart;
        psel && penable && !$past(penable);
    endsequence
    sequence oneWait;
        !pready ##1 (pready && psel && penable);
    endsequence
    // a taken sample ends ready and gets its aligned result
    sequence sampleTaken;
        sampleValid && sampleReady;
    endsequence
    AST_APB_WAIT: assert property (accessStart |-> oneWait)
        else $error("apb answer not after one wait state");
    AST_APB_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_APB_ONLY: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    AST_APB_ERR: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_APB_WRD: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data not zero on a write");
    AST_SMP_BUSY: assert property (sampleTaken |=> !sampleReady)
        else $error("block still ready after taking a sample");
    AST_SMP_DONE: assert property (sampleTaken |-> ##[2:100] (outValid && sampleReady))
        else $error("no result for a taken sample");
    AST_OUT_PULSE: assert property (outValid |=> !outValid)
        else $error("result strobe longer than one cycle");
    AST_OUT_HOLD: assert property (1 ##1 !outValid |->
        $stable(lowBandOutput) && $stable(highBandOutput))
        else $error("band output moved without result strobe");
endmodule // acx_crossover_chk

bind acx_crossover acx_crossover_chk #(.DW(DW)) u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sampleValid(sampleValid), .sampleReady(sampleReady),
    .outValid(outValid), .lowBandOutput(lowBandOutput), .highBandOutput(highBandOutput));
`default_nettype wire

// ---- tb/acx_audio_src.sv ----
// upstream sample source and downstream result counter
`timescale 1ns/1ps
`default_nettype none
module acx_audio_src #(parameter DW = 24) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic start,
    input wire logic signed [DW-1:0] level,
    input wire logic [3:0] gap,
    input wire logic sampleReady,
    input wire logic outValid,
    output logic sampleValid,
    output logic signed [DW-1:0] sampleIn,
    output logic [15:0] gotCnt
);
    logic [3:0] waitCnt;
    logic pend;
    // offer after a gap, hold until taken, then invert released data
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sampleValid <= 1'b0;
            sampleIn <= '0;
            pend <= 1'b0;
            waitCnt <= 4'h0;
            gotCnt <= 16'h0;
        end else begin
            if (outValid) gotCnt <= gotCnt + 16'h1;
            if (start) begin
                pend <= 1'b1;
                waitCnt <= gap;
            end else if (pend && waitCnt != 4'h0) begin
                waitCnt <= waitCnt - 4'h1;
            end else if (pend) begin
                pend <= 1'b0;
                sampleValid <= 1'b1;
                sampleIn <= level;
            end
            if (sampleValid && sampleReady) begin
                sampleValid <= 1'b0;
                sampleIn <= ~sampleIn;
            end
        end
    end
endmodule // acx_audio_src
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking testbench of the audio crossover
`timescale 1ns/1ps
`default_nettype none
`include "acx_defs.vh"
module tb;
    logic clk_sys = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic start = 1'b0, err, ok;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, expv, wv;
    logic signed [23:0] level = 24'sh0;
    logic [3:0] gap = 4'h0;
    logic [15:0] c0;
    wire [31:0] prdata;
    wire pready, pslverr, sampleValid, sampleReady, outValid;
    wire signed [23:0] sampleIn, lowOut, lmOut, umOut, hiOut;
    wire [15:0] gotCnt;
    int errors = 0, compares = 0;
    // 200 MHz system clock
    always #2.5 clk_sys = ~clk_sys;
    acx_crossover #(.DW(24), .IW(28)) u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sampleValid(sampleValid), .sampleIn(sampleIn),
        .sampleReady(sampleReady), .outValid(outValid), .lowBandOutput(lowOut),
        .lowerMiddleBandOutput(lmOut), .upperMiddleBandOutput(umOut), .highBandOutput(hiOut));
    acx_audio_src #(.DW(24)) u_src (.clk_sys(clk_sys), .arst_n(arst_n), .start(start),
        .level(level), .gap(gap), .sampleReady(sampleReady), .outValid(outValid),
        .sampleValid(sampleValid), .sampleIn(sampleIn), .gotCnt(gotCnt));
    task automatic end_of_test;
        if (errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic flag(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask
    // one apb transfer; read data and error taken at the answering edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // one sample through the source, wait for its result
    task automatic send(input logic signed [23:0] v, input logic [3:0] g);
        logic [15:0] base;
        base = gotCnt;
        level <= v;
        gap <= g;
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        while (gotCnt === base) begin
            @(posedge clk_sys);
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (50) @(posedge clk_sys);
        rdchk(`ACX_REG_CTRL, 32'h1);
        rdchk(`ACX_REG_BAND, 32'h0);
        rdchk(`ACX_REG_STAT, 32'h0);
        for (int i = 0; i < 6; i++) rdchk(8'h10 + 8'(4 * i), 32'h000c03e8);
        apb(1'b1, 8'h0c, 32'hffffffff);
        flag(err, 1'b1);
        apb(1'b0, 8'h0c, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        // every family and slope code on one filter
        expv = 32'h000c03e8;
        for (int f = 0; f < 4; f++) for (int s = 0; s < 8; s++) begin
            ok = f == 0 ? s < 6 : f == 1 ? (s > 0 && s < 6) :
                f == 2 ? (s == 1 || s > 2 && s < 6) : 0;
            wv = {11'h0, 3'(s), 2'(f), 16'(2000 + f * 8 + s)};
            if (ok) expv = wv;
            apb(1'b1, 8'h14, wv);
            rdchk(8'h14, expv);
            rdchk(`ACX_REG_STAT, {30'h0, !ok, 1'b0});
            apb(1'b1, `ACX_REG_STAT, 32'h2);
        end
        rdchk(8'h10, 32'h000c03e8);
        // link engage, copy, release and refusal
        apb(1'b1, 8'h14, 32'h000c05dc);
        apb(1'b1, `ACX_REG_CTRL, 32'h11);
        rdchk(`ACX_REG_CTRL, 32'h11);
        apb(1'b1, 8'h10, 32'h000c0929);
        rdchk(8'h14, 32'h000c0929);
        apb(1'b1, `ACX_REG_CTRL, 32'h1);
        apb(1'b1, 8'h10, 32'h000c0100);
        rdchk(8'h14, 32'h000c0929);
        apb(1'b1, 8'h14, 32'h000d0929);
        apb(1'b1, `ACX_REG_CTRL, 32'h11);
        rdchk(`ACX_REG_CTRL, 32'h1);
        rdchk(`ACX_REG_STAT, 32'h2);
        apb(1'b1, `ACX_REG_STAT, 32'h2);
        // two-, three- and four-way audio with a wide open low-pass
        apb(1'b1, 8'h10, 32'h00004e20);
        for (int i = 0; i < 8; i++) send(24'sh400000, 4'(i));
        flag(lowOut > 24'sh0, 1'b1);
        check({8'h0, lmOut | umOut}, 32'h0);
        apb(1'b1, `ACX_REG_BAND, 32'h1);
        send(24'sh400000, 4'h0);
        flag(lowOut < 24'sh0, 1'b1);
        apb(1'b1, `ACX_REG_BAND, 32'h100);
        send(24'sh400000, 4'h3);
        check({8'h0, lowOut}, 32'h0);
        apb(1'b1, `ACX_REG_CTRL, 32'h2);
        apb(1'b1, `ACX_REG_BAND, 32'h200);
        send(24'sh400000, 4'h1);
        check({8'h0, umOut | lmOut}, 32'h0);
        apb(1'b1, `ACX_REG_CTRL, 32'h3);
        apb(1'b1, `ACX_REG_BAND, 32'hf00);
        send(24'sh400000, 4'h0);
        check({8'h0, lowOut | lmOut | umOut | hiOut}, 32'h0);
        apb(1'b1, `ACX_REG_BAND, 32'h0);
        c0 = gotCnt;
        for (int i = 0; i < 4; i++) send(-24'sh123456, 4'h0);
        check({16'h0, gotCnt}, {16'h0, c0 + 16'h4});
        check({8'h0, lowOut}, {8'h0, -24'sh123456});
        flag(hiOut != 24'sh0 && umOut != 24'sh0, 1'b1);
        end_of_test();
    end
endmodule // tb
`default_nettype wire
